//--- hw/flash_cmd_cfg.svh
/*
 * Timing counts and frame constants for the serial flash opcode decoder.
 * Assumes a 100 MHz system clock; opcodes are plain bytes, not listed here.
 */
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

`define CLK_PERIOD_NS      10
`define RESET_BUSY_US      30
`define RESET_BUSY_CYCLES  ((`RESET_BUSY_US * 1000) / `CLK_PERIOD_NS)
`define ADDR_BYTES_STD     3
`define DTR_FAST_DUMMY_CYC 6
`define DTR_DUAL_DUMMY_CYC 6
`define FIFO_DEPTH_DEF     8

`endif

//--- hw/flash_cmd_pkg.sv
/*
 * Types for the serial flash opcode decoder: lane modes, actions, decode record.
 * Assumes the cfg header carries the timing and FIFO constants; most dummy and address counts are literals in the decoder.
 */
package flash_cmd_pkg;

	typedef enum logic [1:0] {
		LANE_SINGLE,
		LANE_DUAL,
		LANE_DTR_SINGLE,
		LANE_DTR_DUAL
	} lane_e;

	typedef enum logic [4:0] {
		ACT_NONE,
		ACT_ARRAY_READ,
		ACT_PAGE_ERASE,
		ACT_SECTOR_ERASE,
		ACT_HALF_BLOCK_ERASE,
		ACT_FULL_BLOCK_ERASE,
		ACT_CHIP_ERASE,
		ACT_PAGE_WRITE,
		ACT_SUSPEND,
		ACT_RESUME,
		ACT_LOCK_ONE,
		ACT_UNLOCK_ONE,
		ACT_LOCK_READ,
		ACT_LOCK_ALL,
		ACT_UNLOCK_ALL,
		ACT_OTP_READ,
		ACT_OTP_WRITE,
		ACT_OTP_ERASE,
		ACT_STATUS_READ,
		ACT_STATUS_WRITE,
		ACT_BUF_WIPE,
		ACT_BUF_FILL,
		ACT_BUF_FETCH,
		ACT_BUF_STORE,
		ACT_BUF_COMMIT,
		ACT_IDENT_READ,
		ACT_DEEP_SLEEP,
		ACT_WAKE,
		ACT_RESET_ARM,
		ACT_RESET
	} action_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] opcode;
		action_e    action;
		lane_e      addr_lane;
		lane_e      data_lane;
		logic [1:0] addr_bytes;
		logic [3:0] dummy_cycles;
		logic       data_in;
		logic       data_out;
		logic       one_byte;
		logic       boundary;
		logic [1:0] sub_sel;
	} decode_s;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} byte_s;

	typedef struct packed {
		logic        valid;
		action_e     action;
		logic [1:0]  sub_sel;
		logic [23:0] address;
		logic        write_permit_latch;
		logic        vol_wel;
	} event_s;

endpackage : flash_cmd_pkg

//--- hw/flash_cmd_fifo.sv
/*
 * Parameterised valid/ready FIFO carrying received data bytes.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module flash_cmd_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end
endmodule : flash_cmd_fifo

//--- hw/flash_cmd_decoder.sv
/*
 * Serial flash instruction front end: samples the SPI pins, decodes the
 * opcode, walks address/dummy/data phases, drives the output lanes, and
 * reports each accepted instruction, other than ACT_NONE, ACT_RESET_ARM and unarmed ACT_RESET ones, as an event.
 * Assumes SCLK, CS_N and IO pins come from another domain (synchronised here),
 * that SCLK is at most about a tenth of CLOCK, and that the array side answers
 * read bytes on RD_DATA whenever RD_REQ pulses.
 */
`timescale 1ns/10ps
`include "flash_cmd_cfg.svh"

module flash_cmd_decoder
	import flash_cmd_pkg::*;
#(
	parameter int RESET_BUSY_CYC = `RESET_BUSY_CYCLES,
	parameter int FIFO_DEPTH     = `FIFO_DEPTH_DEF
) (
	// System
	input  wire logic                  CLOCK,
	input  wire logic                  RESET_N,
	// SPI pins
	input  wire logic                  SCLK,
	input  wire logic                  CS_N,
	input  wire logic [1:0]            IO_IN,
	output logic      [1:0]            IO_OUT,
	output logic      [1:0]            IO_OE,
	// Read data source
	output logic                       RD_REQ,
	input  wire logic [7:0]            RD_DATA,
	// Received data bytes
	output logic                       WR_VALID,
	input  wire logic                  WR_READY,
	output flash_cmd_pkg::byte_s       WR_BYTE,
	// Instruction events and state
	output flash_cmd_pkg::event_s      EVENT,
	output flash_cmd_pkg::decode_s     DECODE,
	output logic                       WRITE_PERMIT_LATCH,
	output logic                       DEEP_SLEEP,
	output logic                       BUSY
);
	import flash_cmd_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_STANDBY
	} phase_e;

	typedef struct packed {
		logic [1:0]  sclk_m, sclk_s, sclk_p;
		logic [1:0]  cs_m, cs_s;
		logic [1:0]  io0_m, io0_s;
		logic [1:0]  io1_m, io1_s;
		phase_e      phase;
		decode_s     dec;
		logic [7:0]  sh;
		logic [3:0]  bits;
		logic [1:0]  abytes;
		logic [23:0] addr;
		logic [3:0]  dcnt;
		logic [7:0]  out_sh;
		logic [3:0]  out_bits;
		logic [1:0]  out_oe;
		logic [1:0]  out_v;
		logic        byte_done;
		logic        rst_armed;
		logic        write_permit_latch;
		logic        vol_wel;
		logic        sleep;
		logic [31:0] busy_cnt;
		event_s      ev;
		byte_s       wb;
		logic        wb_pend;
		logic        rd_req;
	} state_s;

	state_s s_q, s_d;
	logic   fifo_in_ready;
	logic   fifo_out_valid;
	logic [8:0] fifo_out;

	function automatic decode_s decode_op(input logic [7:0] op);
		decode_s d;
		d = '0;
		d.valid = 1'b1;
		d.opcode = op;
		d.addr_lane = LANE_SINGLE;
		d.data_lane = LANE_SINGLE;
		unique case (op)
			8'h03: begin d.action = ACT_ARRAY_READ; d.addr_bytes = 2'd3; d.data_out = 1'b1; end
			8'h0b: begin d.action = ACT_ARRAY_READ; d.addr_bytes = 2'd3; d.dummy_cycles = 4'd8;
				d.data_out = 1'b1; end
			8'h3b: begin d.action = ACT_ARRAY_READ; d.addr_bytes = 2'd3; d.dummy_cycles = 4'd8;
				d.data_out = 1'b1; d.data_lane = LANE_DUAL; end
			8'hbb: begin d.action = ACT_ARRAY_READ; d.addr_bytes = 2'd3; d.dummy_cycles = 4'd4;
				d.addr_lane = LANE_DUAL; d.data_lane = LANE_DUAL; d.data_out = 1'b1; end
			8'h81: begin d.action = ACT_PAGE_ERASE; d.addr_bytes = 2'd3; d.boundary = 1'b1; end
			8'h20: begin d.action = ACT_SECTOR_ERASE; d.addr_bytes = 2'd3; d.boundary = 1'b1; end
			8'h52: begin d.action = ACT_HALF_BLOCK_ERASE; d.addr_bytes = 2'd3; d.boundary = 1'b1; end
			8'hd8: begin d.action = ACT_FULL_BLOCK_ERASE; d.addr_bytes = 2'd3; d.boundary = 1'b1; end
			8'h60, 8'hc7: begin d.action = ACT_CHIP_ERASE; d.boundary = 1'b1; end
			8'h02: begin d.action = ACT_PAGE_WRITE; d.addr_bytes = 2'd3; d.data_in = 1'b1;
				d.boundary = 1'b1; end
			8'h75: begin d.action = ACT_SUSPEND; d.boundary = 1'b1; end
			8'h7a: begin d.action = ACT_RESUME; d.boundary = 1'b1; end
			8'h06: begin d.action = ACT_NONE; d.sub_sel = 2'd1; d.boundary = 1'b1; end
			8'h04: begin d.action = ACT_NONE; d.sub_sel = 2'd2; d.boundary = 1'b1; end
			8'h50: begin d.action = ACT_NONE; d.sub_sel = 2'd3; end
			8'h36: begin d.action = ACT_LOCK_ONE; d.addr_bytes = 2'd3; end
			8'h39: begin d.action = ACT_UNLOCK_ONE; d.addr_bytes = 2'd3; end
			8'h3d: begin d.action = ACT_LOCK_READ; d.addr_bytes = 2'd3; d.data_out = 1'b1; end
			8'h7e: d.action = ACT_LOCK_ALL;
			8'h98: d.action = ACT_UNLOCK_ALL;
			8'h44: begin d.action = ACT_OTP_ERASE; d.addr_bytes = 2'd3; d.boundary = 1'b1; end
			8'h42: begin d.action = ACT_OTP_WRITE; d.addr_bytes = 2'd3; d.data_in = 1'b1;
				d.boundary = 1'b1; end
			8'h48: begin d.action = ACT_OTP_READ; d.addr_bytes = 2'd3; d.dummy_cycles = 4'd8;
				d.data_out = 1'b1; end
			8'h05: begin d.action = ACT_STATUS_READ; d.data_out = 1'b1; d.one_byte = 1'b1; end
			8'h35: begin d.action = ACT_STATUS_READ; d.data_out = 1'b1; d.one_byte = 1'b1;
				d.sub_sel = 2'd1; end
			8'h15: begin d.action = ACT_STATUS_READ; d.data_out = 1'b1; d.one_byte = 1'b1;
				d.sub_sel = 2'd2; end
			8'h01: begin d.action = ACT_STATUS_WRITE; d.data_in = 1'b1; d.one_byte = 1'b1;
				d.boundary = 1'b1; end
			8'h31: begin d.action = ACT_STATUS_WRITE; d.data_in = 1'b1; d.one_byte = 1'b1;
				d.sub_sel = 2'd1; d.boundary = 1'b1; end
			8'h11: begin d.action = ACT_STATUS_WRITE; d.data_in = 1'b1; d.one_byte = 1'b1;
				d.sub_sel = 2'd2; d.boundary = 1'b1; end
			8'h9e: d.action = ACT_BUF_WIPE;
			8'h9a: begin d.action = ACT_BUF_FILL; d.addr_bytes = 2'd3; end
			8'h9c: begin d.action = ACT_BUF_STORE; d.addr_bytes = 2'd3; d.data_in = 1'b1; end
			8'h9b: begin d.action = ACT_BUF_FETCH; d.addr_bytes = 2'd3; d.dummy_cycles = 4'd8;
				d.data_out = 1'b1; end
			8'h9d: begin d.action = ACT_BUF_COMMIT; d.addr_bytes = 2'd3; d.boundary = 1'b1; end
			8'h9f: begin d.action = ACT_IDENT_READ; d.data_out = 1'b1; end
			8'h90: begin d.action = ACT_IDENT_READ; d.addr_bytes = 2'd3; d.data_out = 1'b1;
				d.sub_sel = 2'd1; end
			8'h92: begin d.action = ACT_IDENT_READ; d.addr_bytes = 2'd3; d.dummy_cycles = 4'd8;
				d.data_out = 1'b1; d.data_lane = LANE_DUAL; d.sub_sel = 2'd2; end
			8'hb9: begin d.action = ACT_DEEP_SLEEP; d.boundary = 1'b1; end
			8'hab: begin d.action = ACT_WAKE; d.addr_bytes = 2'd3; d.data_out = 1'b1;
				d.one_byte = 1'b1; end
			8'h0d: begin d.action = ACT_ARRAY_READ; d.addr_bytes = 2'd3; d.data_out = 1'b1;
				d.dummy_cycles = 4'(`DTR_FAST_DUMMY_CYC); d.addr_lane = LANE_DTR_SINGLE;
				d.data_lane = LANE_DTR_SINGLE; end
			8'hbd: begin d.action = ACT_ARRAY_READ; d.addr_bytes = 2'd3; d.data_out = 1'b1;
				d.dummy_cycles = 4'(`DTR_DUAL_DUMMY_CYC); d.addr_lane = LANE_DTR_DUAL;
				d.data_lane = LANE_DTR_DUAL; end
			8'h66: begin d.action = ACT_RESET_ARM; d.boundary = 1'b1; end
			8'h99: begin d.action = ACT_RESET; d.boundary = 1'b1; end
			default: d.valid = 1'b0;
		endcase
		return d;
	endfunction : decode_op

	// Bits moved per sampled edge for a lane mode
	function automatic logic [1:0] lane_bits(input lane_e l);
		return (l == LANE_DUAL || l == LANE_DTR_DUAL) ? 2'd2 : 2'd1;
	endfunction : lane_bits

	function automatic logic is_dtr(input lane_e l);
		return (l == LANE_DTR_SINGLE || l == LANE_DTR_DUAL);
	endfunction : is_dtr

	logic   rise, fall, cs_low, cs_fall, cs_rise;
	logic   in_edge, out_edge;
	lane_e  cur_in_lane;
	decode_s nd;

	always_comb begin
		s_d = s_q;
		nd = '0;
		s_d.sclk_m = {s_q.sclk_m[0], SCLK};
		s_d.sclk_s = {s_q.sclk_s[0], s_q.sclk_m[1]};
		s_d.cs_m   = {s_q.cs_m[0], CS_N};
		s_d.cs_s   = {s_q.cs_s[0], s_q.cs_m[1]};
		s_d.io0_m  = {s_q.io0_m[0], IO_IN[0]};
		s_d.io0_s  = {s_q.io0_s[0], s_q.io0_m[1]};
		s_d.io1_m  = {s_q.io1_m[0], IO_IN[1]};
		s_d.io1_s  = {s_q.io1_s[0], s_q.io1_m[1]};
		rise    = s_q.sclk_s[0] && !s_q.sclk_s[1];
		fall    = !s_q.sclk_s[0] && s_q.sclk_s[1];
		cs_low  = !s_q.cs_s[0];
		cs_fall = !s_q.cs_s[0] && s_q.cs_s[1];
		cs_rise = s_q.cs_s[0] && !s_q.cs_s[1];
		cur_in_lane = (s_q.phase == ST_ADDR) ? s_q.dec.addr_lane : LANE_SINGLE;
		in_edge  = rise || (is_dtr(cur_in_lane) && fall);
		out_edge = fall || (is_dtr(s_q.dec.data_lane) && rise);
		s_d.ev.valid = 1'b0;
		s_d.rd_req = 1'b0;
		if (s_q.wb_pend && fifo_in_ready) begin
			s_d.wb_pend = 1'b0;
		end
		if (s_q.busy_cnt != '0) begin
			s_d.busy_cnt = s_q.busy_cnt - 32'd1;
		end

		if (cs_fall) begin
			s_d.phase = (s_q.busy_cnt != '0) ? ST_STANDBY : ST_OPCODE;
			s_d.bits = '0;
			s_d.byte_done = 1'b0;
			s_d.out_oe = '0;
			// A read cut mid-byte must not leak its shifter into the next frame
			s_d.out_bits = '0;
		end else if (!cs_low) begin
			// Deselect ends a frame; boundary-checked opcodes only execute here
			if (cs_rise && s_q.dec.valid && s_q.phase != ST_STANDBY) begin
				if (!s_q.dec.boundary || (s_q.bits == 4'd0 && s_q.byte_done)) begin
					if (s_q.dec.action != ACT_RESET_ARM) begin
						s_d.rst_armed = 1'b0;
					end
					unique case (s_q.dec.action)
						ACT_NONE: begin
							if (s_q.dec.sub_sel == 2'd1) s_d.write_permit_latch = 1'b1;
							if (s_q.dec.sub_sel == 2'd2) s_d.write_permit_latch = 1'b0;
							if (s_q.dec.sub_sel == 2'd3) s_d.vol_wel = 1'b1;
						end
						ACT_RESET_ARM: s_d.rst_armed = 1'b1;
						ACT_RESET: begin
							if (s_q.rst_armed) begin
								s_d.busy_cnt = 32'(RESET_BUSY_CYC);
								s_d.write_permit_latch = 1'b0;
								s_d.vol_wel = 1'b0;
								s_d.sleep = 1'b0;
							end
						end
						ACT_DEEP_SLEEP: s_d.sleep = 1'b1;
						ACT_WAKE: s_d.sleep = 1'b0;
						default: ;
					endcase
					if (s_q.dec.action != ACT_NONE && s_q.dec.action != ACT_RESET_ARM
						&& !(s_q.dec.action == ACT_RESET && !s_q.rst_armed)) begin
						s_d.ev = '{1'b1, s_q.dec.action, s_q.dec.sub_sel, s_q.addr,
							s_q.write_permit_latch, s_q.vol_wel};
						if (s_q.dec.boundary && s_q.dec.action != ACT_SUSPEND
							&& s_q.dec.action != ACT_RESUME
							&& s_q.dec.action != ACT_DEEP_SLEEP) begin
							s_d.write_permit_latch = 1'b0;
						end
					end
				end else begin
					s_d.rst_armed = 1'b0;
				end
			end
			s_d.phase = ST_IDLE;
			s_d.out_oe = '0;
			s_d.dec.valid = 1'b0;
		end else if (in_edge && s_q.phase inside {ST_OPCODE, ST_ADDR, ST_DUMMY}
			|| (rise && s_q.phase == ST_DATA && !s_q.dec.data_out)) begin
			// Shift in, MSB first; bare opcodes keep counting so a ragged deselect is seen
			if (lane_bits(cur_in_lane) == 2'd2) begin
				s_d.sh = {s_q.sh[5:0], s_q.io1_s[1], s_q.io0_s[1]};
				s_d.bits = s_q.bits + 4'd2;
			end else begin
				s_d.sh = {s_q.sh[6:0], s_q.io0_s[1]};
				s_d.bits = s_q.bits + 4'd1;
			end
			s_d.byte_done = 1'b0;
			if (s_q.phase == ST_DUMMY) begin
				s_d.bits = '0;
				s_d.dcnt = s_q.dcnt - 4'd1;
				if (s_q.dcnt == 4'd1) begin
					s_d.phase = ST_DATA;
					s_d.rd_req = 1'b1;
				end
			end else if (s_d.bits == 4'd8) begin
				s_d.bits = '0;
				s_d.byte_done = 1'b1;
				unique case (s_q.phase)
					ST_OPCODE: begin
						nd = decode_op(s_d.sh);
						if (s_q.sleep && s_d.sh != 8'hab) nd.valid = 1'b0;
						s_d.dec = nd;
						s_d.abytes = nd.addr_bytes;
						s_d.dcnt = nd.dummy_cycles;
						if (!nd.valid) s_d.phase = ST_STANDBY;
						else if (nd.addr_bytes != 2'd0) s_d.phase = ST_ADDR;
						else if (nd.data_in || nd.data_out) begin
							s_d.phase = ST_DATA;
							s_d.rd_req = nd.data_out;
						end else s_d.phase = ST_DATA;
					end
					ST_ADDR: begin
						s_d.addr = {s_q.addr[15:0], s_d.sh};
						s_d.abytes = s_q.abytes - 2'd1;
						if (s_q.abytes == 2'd1) begin
							s_d.phase = (s_q.dcnt != '0) ? ST_DUMMY : ST_DATA;
							s_d.rd_req = (s_q.dcnt == '0) && s_q.dec.data_out;
						end
					end
					default: if (s_q.dec.data_in) begin
						s_d.wb = '{1'b1, s_q.dec.one_byte, s_d.sh};
						s_d.wb_pend = 1'b1;
						if (s_q.dec.one_byte) s_d.dec.data_in = 1'b0;
					end
				endcase
			end
		end else if (out_edge && s_q.phase == ST_DATA && s_q.dec.data_out) begin
			// Output shifts on falling edges, and on both edges in DTR modes, MSB first
			if (s_q.out_bits == 4'd0) begin
				s_d.out_sh = RD_DATA;
				s_d.out_bits = 4'd8;
				s_d.rd_req = !s_q.dec.one_byte;
			end
			if (s_q.out_bits == 4'd0 && s_q.out_oe != '0 && s_q.dec.one_byte) begin
				s_d.out_oe = s_q.out_oe;
			end else if (lane_bits(s_q.dec.data_lane) == 2'd2) begin
				s_d.out_v = (s_q.out_bits == 4'd0) ? RD_DATA[7:6] : s_q.out_sh[7:6];
				s_d.out_sh = ((s_q.out_bits == 4'd0) ? RD_DATA : s_q.out_sh) << 2;
				s_d.out_bits = ((s_q.out_bits == 4'd0) ? 4'd8 : s_q.out_bits) - 4'd2;
				s_d.out_oe = 2'b11;
			end else begin
				s_d.out_v = {(s_q.out_bits == 4'd0) ? RD_DATA[7] : s_q.out_sh[7], 1'b0};
				s_d.out_sh = ((s_q.out_bits == 4'd0) ? RD_DATA : s_q.out_sh) << 1;
				s_d.out_bits = ((s_q.out_bits == 4'd0) ? 4'd8 : s_q.out_bits) - 4'd1;
				s_d.out_oe = 2'b10;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q <= '0;
			s_q.sclk_m <= 2'b00;
			s_q.cs_m <= 2'b11;
			s_q.cs_s <= 2'b11;
		end else begin
			s_q <= s_d;
		end
	end

	// Data bytes queue here so the consumer can stall for up to FIFO_DEPTH bytes without losing SPI bytes
	flash_cmd_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (CLOCK),
		.reset_n   (RESET_N),
		.in_valid  (s_q.wb_pend),
		.in_ready  (fifo_in_ready),
		.in_data   ({s_q.wb.last, s_q.wb.data}),
		.out_valid (fifo_out_valid),
		.out_ready (WR_READY),
		.out_data  (fifo_out)
	);

	assign WR_VALID = fifo_out_valid;
	assign WR_BYTE  = '{fifo_out_valid, fifo_out[8], fifo_out[7:0]};
	// Single lane drives IO1 (SO); dual drives both, IO1 carries the high bit
	assign IO_OUT   = {s_q.out_v[1], s_q.out_v[0]};
	assign IO_OE    = s_q.out_oe;
	assign RD_REQ   = s_q.rd_req;
	assign EVENT    = s_q.ev;
	assign DECODE   = s_q.dec;
	assign WRITE_PERMIT_LATCH = s_q.write_permit_latch;
	assign DEEP_SLEEP = s_q.sleep;
	assign BUSY     = (s_q.busy_cnt != '0);
endmodule : flash_cmd_decoder

//--- verif/spi_host_model.sv
/* SPI host model: mode 0 frames, 125 ns SCLK, transmit on IO0.
   Assumes the bench resolves the shared data pins into io_wire. */
`timescale 1ns/10ps
module spi_host_model (
	// Pins toward the device
	output logic       sclk,
	output logic       cs_n,
	output logic [1:0] host_io,
	// Resolved pin levels
	input wire logic [1:0] io_wire
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_io = 2'b01;
	end

	// SCLK stands low between frames; released lines flip so no stale level lingers
	task automatic xfer(input logic [95:0] tx, input int nb, input int nrx, input bit dual,
			output logic [23:0] rx);
		rx = '0;
		cs_n = 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			host_io = {~host_io[1], tx[i]};
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		for (int j = 0; j < nrx; j++) begin
			host_io = ~host_io;
			#62.5 sclk = 1'b1;
			rx = dual ? {rx[21:0], io_wire} : {rx[22:0], io_wire[1]};
			#62.5 sclk = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		host_io = ~host_io;
		#500;
	endtask : xfer
endmodule : spi_host_model

//--- verif/flash_cmd_decoder_checker.sv
/* Port assertions for the flash opcode decoder.
   Bound to the decoder; single clock domain, active-low async reset. */
`timescale 1ns/10ps
module flash_cmd_decoder_checker #(
	parameter int RESET_BUSY_CYC = 3000
) (
	// System
	input wire logic                 CLOCK,
	input wire logic                 RESET_N,
	// Pins and streams
	input wire logic                 CS_N,
	input wire logic [1:0]           IO_OE,
	input wire logic                 RD_REQ,
	input wire logic                 WR_VALID,
	input wire logic                 WR_READY,
	input wire flash_cmd_pkg::byte_s  WR_BYTE,
	// State
	input wire flash_cmd_pkg::event_s EVENT,
	input wire logic                 WRITE_PERMIT_LATCH,
	input wire logic                 DEEP_SLEEP,
	input wire logic                 BUSY
);
	import flash_cmd_pkg::*;
	localparam int BUSY_LO = RESET_BUSY_CYC - 2;
	localparam int BUSY_HI = RESET_BUSY_CYC + 2;
	logic [15:0] busy_cnt_q;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N)
			busy_cnt_q <= '0;
		else if (BUSY)
			busy_cnt_q <= busy_cnt_q + 16'h0001;
		else
			busy_cnt_q <= '0;
	end

	// Long enough for the pin synchroniser to see the deselect
	sequence s_deselected;
		CS_N [*8];
	endsequence
	sequence s_wake_event;
		EVENT.action == ACT_WAKE;
	endsequence

	property p_idle_released;
		s_deselected |-> IO_OE == 2'b00;
	endproperty
	property p_lane_code;
		IO_OE != 2'b01;
	endproperty
	property p_rdreq_pulse;
		RD_REQ |=> !RD_REQ;
	endproperty
	property p_oe_until_deselect;
		$fell(IO_OE[1]) |-> CS_N && $past(CS_N);
	endproperty
	property p_event_at_deselect;
		EVENT.valid |-> CS_N && $past(CS_N, 2) ##1 !EVENT.valid;
	endproperty
	property p_latch_deselected;
		WRITE_PERMIT_LATCH != $past(WRITE_PERMIT_LATCH) |-> CS_N && $past(CS_N);
	endproperty
	property p_sleep_only_wake;
		DEEP_SLEEP && $past(DEEP_SLEEP) && EVENT.valid |-> s_wake_event;
	endproperty
	property p_busy_mute;
		BUSY && $past(BUSY, 2) |-> !EVENT.valid;
	endproperty
	property p_busy_length;
		$fell(BUSY) |-> busy_cnt_q inside {[BUSY_LO:BUSY_HI]};
	endproperty
	property p_fifo_hold;
		WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_BYTE);
	endproperty

	a_idle_released: assert property (p_idle_released) else $error("output driven while idle");
	a_lane_code: assert property (p_lane_code) else $error("bad lane enable");
	a_rdreq_pulse: assert property (p_rdreq_pulse) else $error("read request too long");
	a_oe_until_deselect: assert property (p_oe_until_deselect) else $error("early release");
	a_event_at_deselect: assert property (p_event_at_deselect) else $error("event timing");
	a_latch_deselected: assert property (p_latch_deselected) else $error("latch moved");
	a_sleep_only_wake: assert property (p_sleep_only_wake) else $error("decoded asleep");
	a_busy_mute: assert property (p_busy_mute) else $error("event while busy");
	a_busy_length: assert property (p_busy_length) else $error("busy length");
	a_fifo_hold: assert property (p_fifo_hold) else $error("byte changed while stalled");
endmodule : flash_cmd_decoder_checker

bind flash_cmd_decoder flash_cmd_decoder_checker #(.RESET_BUSY_CYC(RESET_BUSY_CYC))
	u_flash_cmd_decoder_checker (.CLOCK, .RESET_N, .CS_N, .IO_OE, .RD_REQ, .WR_VALID,
	.WR_READY, .WR_BYTE, .EVENT, .WRITE_PERMIT_LATCH, .DEEP_SLEEP, .BUSY);

//--- verif/serial_flash_opcode_decoder_test.sv
/* Self-checking bench for the flash opcode decoder.
   Assumes the host model drives the SPI pins; the bench is array source and byte sink. */
`timescale 1ns/10ps
module serial_flash_opcode_decoder_test;
	import flash_cmd_pkg::*;
	logic        CLOCK = 1'b0;
	logic        RESET_N = 1'b0;
	logic        WR_READY = 1'b0;
	logic        SCLK, CS_N, RD_REQ, WR_VALID, WRITE_PERMIT_LATCH, DEEP_SLEEP, BUSY, oe_seen;
	logic [1:0]  IO_IN, IO_OUT, IO_OE, host_io, ev_wel;
	logic [7:0]  RD_DATA, src;
	logic [23:0] rx, ev_adr;
	byte_s       WR_BYTE;
	event_s      EVENT;
	decode_s     DECODE;
	action_e     ev_act;
	int          fails, checked, ev_n;

	always #5 CLOCK = ~CLOCK;
	assign IO_IN = (IO_OE & IO_OUT) | (~IO_OE & host_io);

	flash_cmd_decoder #(.RESET_BUSY_CYC(200), .FIFO_DEPTH(8)) u_flash_cmd_decoder (
		.CLOCK, .RESET_N, .SCLK, .CS_N, .IO_IN, .IO_OUT, .IO_OE, .RD_REQ, .RD_DATA,
		.WR_VALID, .WR_READY, .WR_BYTE, .EVENT, .DECODE, .WRITE_PERMIT_LATCH,
		.DEEP_SLEEP, .BUSY);
	spi_host_model u_spi_host_model (.sclk(SCLK), .cs_n(CS_N), .host_io, .io_wire(IO_IN));

	// Array source: every request hands out the next byte of a running count
	always @(negedge CLOCK) begin
		if (RD_REQ === 1'b1) begin
			RD_DATA <= src;
			src <= src + 8'h01;
		end
	end
	always @(posedge CLOCK) begin
		if (EVENT.valid === 1'b1) begin
			ev_act <= EVENT.action;
			ev_adr <= EVENT.address;
			ev_wel <= {EVENT.write_permit_latch, EVENT.vol_wel};
			ev_n <= ev_n + 1;
		end
		if (IO_OE !== 2'b00)
			oe_seen <= 1'b1;
	end

	task automatic compare(input logic [23:0] got, input logic [23:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : compare

	task automatic send(input logic [95:0] tx, input int nb, input int nrx, input bit dual);
		// Start off both clock edges so no pin ever changes on a sampling edge
		@(negedge CLOCK);
		#1.25;
		u_spi_host_model.xfer(tx, nb, nrx, dual, rx);
	endtask : send

	task automatic t_permit;
		send(96'h00c, 9, 0, 0);
		compare(WRITE_PERMIT_LATCH, 0, "ragged set");
		send(96'h06, 8, 0, 0);
		compare(WRITE_PERMIT_LATCH, 1, "set latch");
		send(96'h04, 8, 0, 0);
		compare(WRITE_PERMIT_LATCH, 0, "clear latch");
		send(96'h50, 8, 0, 0);
		compare(WRITE_PERMIT_LATCH, 0, "volatile permit");
	endtask : t_permit

	task automatic t_actions;
		logic [7:0] ops[17] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h36, 8'h39, 8'h3d, 8'h44, 8'h9a,
			8'h9d, 8'h60, 8'hc7, 8'h75, 8'h7a, 8'h7e, 8'h98, 8'h9e};
		action_e acts[17] = '{ACT_PAGE_ERASE, ACT_SECTOR_ERASE, ACT_HALF_BLOCK_ERASE,
			ACT_FULL_BLOCK_ERASE, ACT_LOCK_ONE, ACT_UNLOCK_ONE, ACT_LOCK_READ, ACT_OTP_ERASE,
			ACT_BUF_FILL, ACT_BUF_COMMIT, ACT_CHIP_ERASE, ACT_CHIP_ERASE, ACT_SUSPEND,
			ACT_RESUME, ACT_LOCK_ALL, ACT_UNLOCK_ALL, ACT_BUF_WIPE};
		int n;
		for (int i = 0; i < 17; i++) begin
			n = ev_n;
			send(i < 10 ? {ops[i], 24'h0a1b2c} : ops[i], i < 10 ? 32 : 8, 0, 0);
			compare(ev_n - n, 1, "event count");
			compare(ev_act, acts[i], "action");
			if (i < 10)
				compare(ev_adr, 24'h0a1b2c, "address");
			if (i == 0)
				compare(ev_wel, 2'b01, "permits at event");
		end
		n = ev_n;
		send({8'h81, 24'h0a1b2c, 1'b0}, 33, 0, 0);
		compare(ev_n - n, 0, "ragged erase");
		oe_seen = 1'b0;
		send(96'hf0, 8, 16, 0);
		compare(oe_seen, 0, "unknown opcode drove");
		compare(ev_n - n, 0, "unknown opcode event");
	endtask : t_actions

	task automatic t_reads;
		logic [7:0] ops[11] = '{8'h03, 8'h0b, 8'h3b, 8'h05, 8'h35, 8'h15, 8'h9f, 8'h90, 8'h48,
			8'h9b, 8'h92};
		int nb[11] = '{32, 40, 40, 8, 8, 8, 8, 32, 40, 40, 40};
		int nrx[11] = '{16, 16, 8, 8, 8, 8, 24, 16, 8, 8, 8};
		logic [23:0] exp;
		logic [7:0] b;
		bit dual;
		for (int i = 0; i < 11; i++) begin
			b = src;
			exp = '0;
			dual = ops[i] inside {8'h3b, 8'h92};
			send({ops[i], 24'h0a1b2c, 8'h00} >> (40 - nb[i]), nb[i], nrx[i], dual);
			for (int k = 0; k < (dual ? nrx[i] / 4 : nrx[i] / 8); k++)
				exp = {exp[15:0], b + 8'(k)};
			compare(rx, exp, "read data");
			compare({DECODE.valid, DECODE.opcode}, {1'b0, ops[i]}, "decode");
			compare(DECODE.data_lane, dual ? LANE_DUAL : LANE_SINGLE, "lane");
		end
	endtask : t_reads

	task automatic t_page;
		logic [63:0] d = 64'h1122334455667788;
		int k = 0;
		send(96'h06, 8, 0, 0);
		send({8'h02, 24'h0a1b2c, d}, 96, 0, 0);
		compare(ev_act, ACT_PAGE_WRITE, "program");
		compare(WRITE_PERMIT_LATCH, 0, "latch after program");
		compare(WR_VALID, 1, "stalled bytes");
		@(negedge CLOCK) WR_READY = 1'b1;
		for (int t = 0; t < 40 && k < 8; t++) begin
			if (WR_VALID === 1'b1) begin
				compare(WR_BYTE.data, d[63 - 8 * k -: 8], "program byte");
				k++;
			end
			@(negedge CLOCK);
		end
		compare(k, 8, "program count");
		WR_READY = 1'b0;
		send({8'h01, 8'h3c}, 16, 0, 0);
		compare(WR_BYTE, {2'b11, 8'h3c}, "status byte");
		@(negedge CLOCK) WR_READY = 1'b1;
		@(negedge CLOCK) WR_READY = 1'b0;
	endtask : t_page

	task automatic t_reset;
		send(96'h66, 8, 0, 0);
		send(96'h50, 8, 0, 0);
		send(96'h99, 8, 0, 0);
		compare(BUSY, 0, "split reset");
		send(96'h06, 8, 0, 0);
		send(96'h66, 8, 0, 0);
		send(96'h99, 8, 0, 0);
		compare(BUSY, 1, "reset busy");
		send(96'h06, 8, 0, 0);
		for (int t = 0; t < 400 && BUSY !== 1'b0; t++)
			@(negedge CLOCK);
		compare(BUSY, 0, "busy ends");
		compare(WRITE_PERMIT_LATCH, 0, "ignored while busy");
	endtask : t_reset

	task automatic t_sleep;
		logic [7:0] b;
		send(96'hb9, 8, 0, 0);
		compare(DEEP_SLEEP, 1, "sleep");
		send(96'h06, 8, 0, 0);
		compare(WRITE_PERMIT_LATCH, 0, "decoded asleep");
		b = src;
		send({8'hab, 24'h000000}, 32, 8, 0);
		compare(DEEP_SLEEP, 0, "wake");
		compare(rx, b, "signature");
	endtask : t_sleep

	task automatic results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	initial begin
		RD_DATA = 8'h00;
		src = 8'h5a;
		repeat (2) @(posedge CLOCK);
		@(negedge CLOCK) RESET_N = 1'b1;
		repeat (4) @(negedge CLOCK);
		t_permit;
		t_actions;
		t_reads;
		t_page;
		t_reset;
		t_sleep;
		results;
	end

	// Whole sequence needs about 170 us of frames
	initial begin
		#600us;
		fails++;
		results;
	end
endmodule : serial_flash_opcode_decoder_test
